// ### mad_pkg.sv
// Package for the accumulator move/arithmetic datapath.
// Assumes a single aclk domain and an AXI4-Lite master for control.
package mad_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] MAD_OFF_CMD   = 8'h00;
    localparam logic [7:0] MAD_OFF_FLAGS = 8'h04;
    localparam logic [7:0] MAD_OFF_WREG  = 8'h08;
    localparam logic [7:0] MAD_OFF_SP    = 8'h0C;
    localparam logic [7:0] MAD_OFF_MADDR = 8'h10;
    localparam logic [7:0] MAD_OFF_MDATA = 8'h14;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int         MAD_CMD_OP_LSB  = 0;
    localparam int         MAD_CMD_DST_BIT = 8;
    localparam int         MAD_CMD_OPD_LSB = 16;
    localparam int         MAD_BUSY_BIT    = 8;
    localparam logic [7:0] MAD_RST_BYTE    = 8'h00;
    localparam logic [3:0] MAD_RST_FLAGS   = 4'h0;
    localparam logic [1:0] MAD_RESP_OKAY   = 2'b00;
    localparam logic [1:0] MAD_RESP_SLVERR = 2'b10;
    localparam logic [7:0] MAD_SP_STEP     = 8'h02;
    localparam logic [7:0] MAD_ONE         = 8'h01;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        MAD_OP_NOP, MAD_OP_IDX_STORE, MAD_OP_XCH, MAD_OP_PUSH, MAD_OP_POP,
        MAD_OP_ADD_I, MAD_OP_ADD_M, MAD_OP_ADDC_M, MAD_OP_ADDC_1,
        MAD_OP_SUB_I, MAD_OP_SUB_M, MAD_OP_SUBC_M, MAD_OP_SUBC_1,
        MAD_OP_INC, MAD_OP_DEC, MAD_OP_CLEAR
    } mad_op_e;

    typedef struct packed {
        logic [7:0] operand;
        logic       dst_mem;
        mad_op_e    op;
    } mad_cmd_s;

    typedef struct packed {
        logic ov;
        logic ac;
        logic c;
        logic z;
    } mad_flags_s;

endpackage

// ### mad_datapath.sv
// Accumulator datapath with its own data memory, controlled over AXI4-Lite.
// Assumes one aclk domain and a master that follows AXI4-Lite handshakes.
`timescale 1ns/100ps

// Contract
// - Indirect store writes working register at pointer address, two cycles, flags kept.
// - Exchange swaps working register and memory byte, flags kept.
// - Save writes flags and working register at stack pointer, then adds two.
// - Restore subtracts two from stack pointer, then loads flags and register.
// - Add immediate into working register, updating all four flags.
// - Add memory byte, result to register or memory, all flags updated.
// - Add with carry of two operands, chosen destination, all flags updated.
// - Single operand add with carry adds carry only, in place.
// - Subtract immediate via two's complement into working register, flags updated.
// - Memory subtraction in either direction via two's complement, flags updated.
// - Two operand subtract with borrow removes operand and carry from destination.
// - Single operand subtract with borrow removes carry only, in place.
// - Increment adds one to memory byte, all flags updated.
// - Decrement subtracts one from memory byte, all flags updated.
// - Clear writes zero to memory byte, flags kept.
// - Zero flag on zero result; nibble carry on low nibble carry out or borrow.
// - Carry is carry out or borrow; overflow flags signed range error.
module mad_datapath
    import mad_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int MEM_AW = 8
) (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // Write address channel
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // Write data channel
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // Write response channel
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // Read address channel
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // Read data channel
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {MAD_ST_IDLE, MAD_ST_EXEC, MAD_ST_IDX2} mad_state_e;

    logic [7:0]        mem_r [2**MEM_AW];
    mad_state_e        state_r;
    mad_cmd_s          cmd_r;
    mad_flags_s        flags_r;
    logic [7:0]        wreg_r;
    logic [7:0]        sp_r;
    logic [7:0]        maddr_r;
    logic [7:0]        ptr_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0]       wdata_r;
    logic [3:0]        wstrb_r;
    logic              aw_hold_r;
    logic              w_hold_r;
    logic              wr_fire;
    logic              busy;
    logic [7:0]        wr_off;

    assign busy    = (state_r != MAD_ST_IDLE);
    assign wr_fire = aw_hold_r && w_hold_r && !s_axi_bvalid;
    assign wr_off  = 8'(awaddr_r);

    // ------------------------------------------------------------
    // AXI write path
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            aw_hold_r     <= 1'b0;
            awaddr_r      <= '0;
        end else if (s_axi_awready && s_axi_awvalid) begin
            s_axi_awready <= 1'b0;
            aw_hold_r     <= 1'b1;
            awaddr_r      <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_hold_r     <= 1'b0;
        end else if (!aw_hold_r && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b0;
            w_hold_r     <= 1'b0;
            wdata_r      <= '0;
            wstrb_r      <= '0;
        end else if (s_axi_wready && s_axi_wvalid) begin
            s_axi_wready <= 1'b0;
            w_hold_r     <= 1'b1;
            wdata_r      <= s_axi_wdata;
            wstrb_r      <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_hold_r     <= 1'b0;
        end else if (!w_hold_r && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= MAD_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_off > MAD_OFF_MDATA || wr_off[1:0] != 2'b00) ? MAD_RESP_SLVERR : MAD_RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Software writes land only while idle; a busy datapath owns them
    logic sw_cmd;
    logic sw_flags;
    logic sw_wreg;
    logic sw_sp;
    logic sw_maddr;
    logic sw_mdata;
    assign sw_cmd   = wr_fire && !busy && wr_off == MAD_OFF_CMD && (&wstrb_r[2:0]);
    assign sw_flags = wr_fire && !busy && wr_off == MAD_OFF_FLAGS && wstrb_r[0];
    assign sw_wreg  = wr_fire && !busy && wr_off == MAD_OFF_WREG && wstrb_r[0];
    assign sw_sp    = wr_fire && !busy && wr_off == MAD_OFF_SP && wstrb_r[0];
    assign sw_maddr = wr_fire && !busy && wr_off == MAD_OFF_MADDR && wstrb_r[0];
    assign sw_mdata = wr_fire && !busy && wr_off == MAD_OFF_MDATA && wstrb_r[0];

    // ------------------------------------------------------------
    // AXI read path
    // ------------------------------------------------------------
    logic [7:0] rd_off;
    assign rd_off = 8'(s_axi_araddr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= MAD_RESP_OKAY;
        end else if (s_axi_arready && s_axi_arvalid) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= MAD_RESP_OKAY;
            s_axi_rdata   <= '0;
            case (rd_off)
                MAD_OFF_CMD:   s_axi_rdata <= 32'(cmd_r);
                MAD_OFF_FLAGS: s_axi_rdata <= 32'({busy, 4'h0, flags_r});
                MAD_OFF_WREG:  s_axi_rdata <= 32'(wreg_r);
                MAD_OFF_SP:    s_axi_rdata <= 32'(sp_r);
                MAD_OFF_MADDR: s_axi_rdata <= 32'(maddr_r);
                MAD_OFF_MDATA: s_axi_rdata <= 32'(mem_r[MEM_AW'(maddr_r)]);
                default:       s_axi_rresp <= MAD_RESP_SLVERR;
            endcase
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Operand selection and adder
    // ------------------------------------------------------------
    logic [7:0]  mem_rd;
    logic [7:0]  opa;
    logic [7:0]  opb;
    logic        cin;
    logic        is_sub;
    logic [7:0]  opb_x;
    logic        cin_x;
    logic [8:0]  sum;
    logic [4:0]  nib;
    mad_flags_s  alu_flags;

    assign mem_rd = mem_r[MEM_AW'(cmd_r.operand)];

    always_comb begin
        opa    = cmd_r.dst_mem ? mem_rd : wreg_r;
        opb    = cmd_r.dst_mem ? wreg_r : mem_rd;
        cin    = 1'b0;
        is_sub = 1'b0;
        case (cmd_r.op)
            MAD_OP_ADD_I: begin
                opa = wreg_r;
                opb = cmd_r.operand;
            end
            MAD_OP_ADDC_M: cin = flags_r.c;
            MAD_OP_ADDC_1: begin
                opb = '0;
                cin = flags_r.c;
            end
            MAD_OP_SUB_I: begin
                opa    = wreg_r;
                opb    = cmd_r.operand;
                is_sub = 1'b1;
            end
            MAD_OP_SUB_M: is_sub = 1'b1;
            MAD_OP_SUBC_M: begin
                is_sub = 1'b1;
                cin    = flags_r.c;
            end
            MAD_OP_SUBC_1: begin
                opb    = '0;
                is_sub = 1'b1;
                cin    = flags_r.c;
            end
            MAD_OP_INC: begin
                opa = mem_rd;
                opb = MAD_ONE;
            end
            MAD_OP_DEC: begin
                opa    = mem_rd;
                opb    = MAD_ONE;
                is_sub = 1'b1;
            end
            default: begin
                opb = cmd_r.dst_mem ? wreg_r : mem_rd;
            end
        endcase
    end

    // Subtraction as a + ~b + ~borrow, so one adder serves both
    // two's complement form
    assign opb_x = is_sub ? ~opb : opb;
    assign cin_x = is_sub ? ~cin : cin;
    assign sum   = {1'b0, opa} + {1'b0, opb_x} + {8'h00, cin_x};
    assign nib   = {1'b0, opa[3:0]} + {1'b0, opb_x[3:0]} + {4'h0, cin_x};

    always_comb begin
        alu_flags.z  = (sum[7:0] == MAD_RST_BYTE);
        alu_flags.ac = nib[4] ^ is_sub;
        alu_flags.c  = sum[8] ^ is_sub;
        alu_flags.ov = (opa[7] == opb_x[7]) && (sum[7] != opa[7]);
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    logic arith;
    logic to_mem;
    assign arith  = cmd_r.op inside {MAD_OP_ADD_I, MAD_OP_ADD_M, MAD_OP_ADDC_M, MAD_OP_ADDC_1,
                                     MAD_OP_SUB_I, MAD_OP_SUB_M, MAD_OP_SUBC_M, MAD_OP_SUBC_1,
                                     MAD_OP_INC, MAD_OP_DEC};
    assign to_mem = (cmd_r.op inside {MAD_OP_INC, MAD_OP_DEC}) ||
                    (cmd_r.dst_mem && !(cmd_r.op inside {MAD_OP_ADD_I, MAD_OP_SUB_I}));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= MAD_ST_IDLE;
            cmd_r   <= '0;
            ptr_r   <= MAD_RST_BYTE;
        end else begin
            case (state_r)
                MAD_ST_IDLE: begin
                    if (sw_cmd) begin
                        cmd_r   <= mad_cmd_s'({wdata_r[MAD_CMD_OPD_LSB +: 8], wdata_r[MAD_CMD_DST_BIT],
                                               wdata_r[MAD_CMD_OP_LSB +: 5]});
                        state_r <= MAD_ST_EXEC;
                    end
                end
                MAD_ST_EXEC: begin
                    // first cycle fetches pointer low byte
                    // high byte of the pointer word is not used
                    if (cmd_r.op == MAD_OP_IDX_STORE) begin
                        ptr_r   <= mem_r[MEM_AW'({cmd_r.operand[7:1], 1'b0})];
                        state_r <= MAD_ST_IDX2;
                    end else begin
                        state_r <= MAD_ST_IDLE;
                    end
                end
                MAD_ST_IDX2: state_r <= MAD_ST_IDLE;
                default:     state_r <= MAD_ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Data memory (no reset; contents undefined until written)
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (sw_mdata) begin
            mem_r[MEM_AW'(maddr_r)] <= wdata_r[7:0];
        end else if (state_r == MAD_ST_IDX2) begin
            mem_r[MEM_AW'(ptr_r)] <= wreg_r;
        end else if (state_r == MAD_ST_EXEC) begin
            case (cmd_r.op)
                MAD_OP_XCH: mem_r[MEM_AW'(cmd_r.operand)] <= wreg_r;
                MAD_OP_PUSH: begin
                    mem_r[MEM_AW'(sp_r)]                <= wreg_r;
                    mem_r[MEM_AW'(sp_r + MAD_ONE)]      <= {4'h0, flags_r};
                end
                MAD_OP_CLEAR: mem_r[MEM_AW'(cmd_r.operand)] <= MAD_RST_BYTE;
                default: begin
                    if (arith && to_mem) begin
                        mem_r[MEM_AW'(cmd_r.operand)] <= sum[7:0];
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Working register, flags, stack pointer, host address
    // ------------------------------------------------------------
    logic [7:0] pop_sp;
    assign pop_sp = sp_r - MAD_SP_STEP;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wreg_r  <= MAD_RST_BYTE;
            flags_r <= MAD_RST_FLAGS;
            sp_r    <= MAD_RST_BYTE;
            maddr_r <= MAD_RST_BYTE;
        end else begin
            if (sw_wreg)  wreg_r  <= wdata_r[7:0];
            if (sw_flags) flags_r <= wdata_r[3:0];
            if (sw_sp)    sp_r    <= wdata_r[7:0];
            if (sw_maddr) maddr_r <= wdata_r[7:0];
            if (state_r == MAD_ST_EXEC) begin
                case (cmd_r.op)
                    MAD_OP_XCH: wreg_r <= mem_rd;
                    MAD_OP_PUSH: sp_r <= sp_r + MAD_SP_STEP;
                    MAD_OP_POP: begin
                        sp_r    <= pop_sp;
                        wreg_r  <= mem_r[MEM_AW'(pop_sp)];
                        flags_r <= mem_r[MEM_AW'(pop_sp + MAD_ONE)][3:0];
                    end
                    default: begin
                        if (arith) begin
                            flags_r <= alu_flags;
                            if (!to_mem) wreg_r <= sum[7:0];
                        end
                    end
                endcase
            end
        end
    end

endmodule

// ### mad_datapath_chk.sv
// Bus checker for the accumulator datapath, bound to its ports.
// Assumes one aclk domain with a synchronous active-low reset.
`timescale 1ns/100ps
module mad_datapath_chk
    import mad_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic              aclk,
    input wire logic              aresetn,
    // Write side
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic [31:0]       s_axi_wdata,
    input wire logic [3:0]        s_axi_wstrb,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    // Read side
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready
);
    // ------------------------------------
    // Write pairing
    // ------------------------------------
    // Address and data may land on different edges
    logic aw_got_r;
    logic w_got_r;
    logic both_in;
    assign both_in = (aw_got_r || (s_axi_awvalid && s_axi_awready)) && (w_got_r || (s_axi_wvalid && s_axi_wready));
    always_ff @(posedge aclk) begin
        if (!aresetn || s_axi_bvalid) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
        end else begin
            aw_got_r <= aw_got_r || (s_axi_awvalid && s_axi_awready);
            w_got_r  <= w_got_r || (s_axi_wvalid && s_axi_wready);
        end
    end
    // ------------------------------------
    // Assertions
    // ------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_ar_bad;
        s_ar_take ##0 (s_axi_araddr[1:0] != 2'b00 || s_axi_araddr > ADDR_W'(MAD_OFF_MDATA));
    endsequence
    // Both halves held one edge before the response is launched
    a_write_answer: assert property (aw_got_r && w_got_r && !s_axi_bvalid |=> s_axi_bvalid)
        else $error("write response missing");
    a_bvalid_cause: assert property ($rose(s_axi_bvalid) |-> $past(both_in))
        else $error("write response without request");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_read_answer: assert property (s_ar_take |=> s_axi_rvalid)
        else $error("read data missing");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_busy_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_bad_read: assert property (s_ar_bad |=> s_axi_rresp == MAD_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_wreg_width: assert property (s_ar_take ##0 s_axi_araddr == ADDR_W'(MAD_OFF_WREG) |=> s_axi_rdata[31:8] == 24'h0)
        else $error("working register wider than a byte");
    a_ar_return: assert property (s_axi_rvalid && s_axi_rready |-> ##[1:2] s_axi_arready)
        else $error("read address channel not reopened");
endmodule

bind mad_datapath mad_datapath_chk #(.ADDR_W(ADDR_W)) mad_datapath_chk_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// ### mad_datapath_test.sv
// Self-checking bench for the accumulator datapath over AXI4-Lite.
// Assumes mad_pkg, the design and its bound checker compiled first.
`timescale 1ns/100ps
module mad_datapath_test import mad_pkg::*; ;
    // ------------------------------------
    // Signals
    // ------------------------------------
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, v;
    logic [3:0]  wstrb;
    wire         awready, wready, bvalid, arready, rvalid;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    int          error_cnt, check_count, cyc;

    mad_datapath mad_datapath_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    // Hang guard, generous against the some 2600 clock cycles the whole bench takes
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            print_verdict();
        end
    end
    // ------------------------------------
    // Bus tasks
    // ------------------------------------
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er = MAD_RESP_OKAY);
        @(posedge aclk);
        awaddr  <= ad;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", 32'(bresp), 32'(er));
    endtask
    task automatic rd(input logic [7:0] ad, output logic [31:0] d, input logic [1:0] er = MAD_RESP_OKAY);
        @(posedge aclk);
        araddr  <= ad;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        chk("rresp", 32'(rresp), 32'(er));
    endtask
    task automatic rc(input logic [7:0] ad, input logic [31:0] e, input string nm);
        rd(ad, v);
        chk(nm, v, e);
    endtask
    task automatic mset(input logic [7:0] a, input logic [7:0] d);
        wr(MAD_OFF_MADDR, {24'h0, a});
        wr(MAD_OFF_MDATA, {24'h0, d});
    endtask
    task automatic mchk(input logic [7:0] a, input logic [7:0] e, input string nm);
        wr(MAD_OFF_MADDR, {24'h0, a});
        rc(MAD_OFF_MDATA, {24'h0, e}, nm);
    endtask
    // Polls busy; the one or two busy cycles end before the first poll read is taken
    task automatic run(input logic [4:0] op, input logic d, input logic [7:0] opd);
        wr(MAD_OFF_CMD, {8'h00, opd, 7'h00, d, 3'h0, op});
        do rd(MAD_OFF_FLAGS, v); while (v[MAD_BUSY_BIT] !== 1'b0);
    endtask
    // ------------------------------------
    // Scenarios
    // ------------------------------------
    task automatic t_reset;
        rc(MAD_OFF_WREG, 32'h0, "wreg_reset");
        rc(MAD_OFF_FLAGS, 32'h0, "flags_reset");
        rc(MAD_OFF_SP, 32'h0, "sp_reset");
    endtask
    task automatic t_refuse;
        rd(8'h18, v, MAD_RESP_SLVERR);
        chk("unmapped_data", v, 32'h0);
        rd(8'h02, v, MAD_RESP_SLVERR);
        wr(8'h1C, 32'h5A, MAD_RESP_SLVERR);
    endtask
    task automatic t_idx;
        mset(8'h30, 8'h5B);
        mset(8'h31, 8'h00);
        wr(MAD_OFF_WREG, 32'hA5);
        wr(MAD_OFF_FLAGS, 32'hA);
        run(5'h01, 1'b0, 8'h30);
        mchk(8'h5B, 8'hA5, "idx_target");
        rc(MAD_OFF_FLAGS, 32'hA, "idx_flags");
    endtask
    task automatic t_xch;
        wr(MAD_OFF_WREG, 32'h3C);
        mset(8'h44, 8'hC3);
        wr(MAD_OFF_FLAGS, 32'h5);
        run(5'h02, 1'b0, 8'h44);
        rc(MAD_OFF_WREG, 32'hC3, "xch_wreg");
        mchk(8'h44, 8'h3C, "xch_mem");
        rc(MAD_OFF_FLAGS, 32'h5, "xch_flags");
    endtask
    task automatic t_stack;
        wr(MAD_OFF_SP, 32'h20);
        wr(MAD_OFF_WREG, 32'hA5);
        wr(MAD_OFF_FLAGS, 32'hB);
        run(5'h03, 1'b0, 8'h00);
        mchk(8'h20, 8'hA5, "save_wreg");
        mchk(8'h21, 8'h0B, "save_flags");
        rc(MAD_OFF_SP, 32'h22, "save_sp");
        wr(MAD_OFF_WREG, 32'h0);
        wr(MAD_OFF_FLAGS, 32'h0);
        run(5'h04, 1'b0, 8'h00);
        rc(MAD_OFF_SP, 32'h20, "restore_sp");
        rc(MAD_OFF_WREG, 32'hA5, "restore_wreg");
        rc(MAD_OFF_FLAGS, 32'hB, "restore_flags");
    endtask
    task automatic arith(input logic [4:0] op, input logic d, input logic [7:0] w, m, input logic c);
        logic       sb, tm, ci;
        logic [7:0] a, b, r;
        logic [8:0] s;
        logic [4:0] n;
        logic [3:0] f0, f;
        sb = op inside {9, 10, 11, 12, 14};
        tm = (op > 12) || (d && op inside {6, 7, 8, 10, 11, 12});
        a  = tm ? m : w;
        b  = op inside {8, 12} ? 8'h00 : op inside {13, 14} ? 8'h01 : tm ? w : m;
        ci = op inside {7, 8, 11, 12} ? c : 1'b0;
        b  = sb ? ~b : b;
        ci = sb ? ~ci : ci;
        s  = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        n  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        r  = s[7:0];
        f0 = {1'b1, 1'b0, c, 1'b1};
        f  = {(a[7] == b[7]) && (r[7] != a[7]), n[4] ^ sb, s[8] ^ sb, r == 8'h00};
        if (op == 15) begin
            r = 8'h00;
            f = f0;
        end
        wr(MAD_OFF_WREG, {24'h0, w});
        wr(MAD_OFF_FLAGS, {28'h0, f0});
        mset(8'h40, m);
        run(op, d, op inside {5, 9} ? m : 8'h40);
        rc(MAD_OFF_WREG, {24'h0, tm ? w : r}, "arith_wreg");
        rc(MAD_OFF_FLAGS, {28'h0, f}, "arith_flags");
        mchk(8'h40, tm ? r : m, "arith_mem");
    endtask
    // Operand sets aimed at signed, unsigned and nibble edges
    task automatic t_arith;
        logic [7:0] ws[4] = '{8'h7F, 8'hFF, 8'h01, 8'h80};
        logic [7:0] ms[4] = '{8'h81, 8'h01, 8'h01, 8'hFF};
        logic       cs[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        for (int op = 5; op < 16; op++) begin
            for (int d = 0; d < (op inside {6, 7, 8, 10, 11, 12} ? 2 : 1); d++) begin
                for (int i = 0; i < 4; i++) begin
                    arith(5'(op), 1'(d), ws[i], ms[i], cs[i]);
                end
            end
        end
    endtask
    task automatic print_verdict;
        if (error_cnt == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------
    // Main sequence
    // ------------------------------------
    initial begin
        error_cnt = 0;
        check_count = 0;
        cyc = 0;
        aresetn <= 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
        {awaddr, araddr, wdata} <= 48'h0;
        wstrb <= 4'hF;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_refuse();
        t_idx();
        t_xch();
        t_stack();
        t_arith();
        print_verdict();
    end
endmodule
